// ==== design/pal_cfg.svh ====
// Offsets, fields, reset values and timing constants of the PAL sync block
`ifndef PAL_CFG_SVH
`define PAL_CFG_SVH

// Register offsets
`define PAL_OFS_MODE_PRI 8'h00
`define PAL_OFS_MODE_SEC 8'h01
`define PAL_OFS_VBI_LO 8'h02
`define PAL_OFS_VBI_HI 8'h03
`define PAL_OFS_SYNC_ADJ 8'h04
`define PAL_OFS_IDENT 8'h05
`define PAL_RW_RESET 8'h00

// Primary mode register fields
`define PAL_BIT_STD 0
`define PAL_BIT_SCR 1
`define PAL_BIT_VID 2
`define PAL_BIT_WIDE 3
`define PAL_BIT_SELF 4
`define PAL_BIT_BAR 5
`define PAL_BIT_BLACK 6
`define PAL_BIT_CONV 7

// Times in us, clock in MHz
`define PAL_CLK_MHZ 200.0
`define PAL_T_LINE_US 64.0
`define PAL_T_HSYNC_US 4.7
`define PAL_T_EQ_US 2.35
`define PAL_T_BURST_US 5.6
`define PAL_T_ACTIVE_US 10.5
`define PAL_T_ACTLEN_US 52.0
`define PAL_BURST_CYCLES 10
`define PAL_LINES 625

// Cycle counts, rounded to nearest
`define PAL_CYC(t) ($rtoi((t) * `PAL_CLK_MHZ + 0.5))
`define PAL_LINE_CYC `PAL_CYC(`PAL_T_LINE_US)
`define PAL_HSYNC_CYC `PAL_CYC(`PAL_T_HSYNC_US)
`define PAL_EQ_CYC `PAL_CYC(`PAL_T_EQ_US)
`define PAL_BURST_CYC `PAL_CYC(`PAL_T_BURST_US)
`define PAL_ACTIVE_CYC `PAL_CYC(`PAL_T_ACTIVE_US)
`define PAL_ACTLEN_CYC `PAL_CYC(`PAL_T_ACTLEN_US)

// Sub-carrier step: 4.43361875 MHz on a 32-bit accumulator at 200 MHz
`define PAL_NCO_STEP 32'h05accef2

// +135 and -135 degree offsets on a 256-step circle
`define PAL_PH_PLUS 8'h60
`define PAL_PH_MINUS 8'ha0

// Black level codes
`define PAL_BLACK_Y 8'h10
`define PAL_BLACK_C 8'h80

`endif

// ==== design/pal_pkg.sv ====
// Types of the PAL sync block
package pal_pkg;

    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cb;
        logic [7:0] cr;
    } pal_pix_t;

    typedef struct packed {
        logic converter_enable;
        logic black_level_enable;
        logic colour_bar_enable;
        logic self_timing_select;
        logic widescreen_line_enable;
        logic video_id_line_enable;
        logic subcarrier_reset_release;
        logic video_standard_select;
    } pal_mode_t;

    typedef enum logic [1:0] {
        PAL_HALF_NORMAL,
        PAL_HALF_EQ,
        PAL_HALF_BROAD
    } pal_half_t;

    typedef enum logic [2:0] {
        PAL_I2C_IDLE,
        PAL_I2C_DEV,
        PAL_I2C_SUB,
        PAL_I2C_WR,
        PAL_I2C_RD
    } pal_i2c_state_t;

endpackage

// ==== design/pal_i2c_slave.sv ====
// Two-wire serial slave for register access
`timescale 1ns/1ps
`default_nettype none

module pal_i2c_slave import pal_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = 7'h44
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Register access
    output logic wr_r,
    output logic [7:0] wr_addr_r,
    output logic [7:0] wr_data_r,
    output logic [7:0] ptr_r,
    input wire logic [7:0] rd_data
);

    pal_i2c_state_t st_r, st_nxt;
    logic scl_d_r, sda_d_r;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt, ptr_nxt, wr_addr_nxt, wr_data_nxt;
    logic ack_r, ack_nxt, drive_r, drive_nxt, wr_nxt;
    logic scl_rise, scl_fall, start, stop;

    assign scl_rise = scl_in & ~scl_d_r;
    assign scl_fall = ~scl_in & scl_d_r;
    assign start = scl_in & scl_d_r & sda_d_r & ~sda_in;
    assign stop = scl_in & scl_d_r & ~sda_d_r & sda_in;
    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = drive_r;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        ptr_nxt = ptr_r;
        ack_nxt = ack_r;
        drive_nxt = drive_r;
        wr_nxt = 1'b0;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        if (start) begin
            st_nxt = PAL_I2C_DEV;
            cnt_nxt = 4'h0;
            ack_nxt = 1'b0;
            drive_nxt = 1'b0;
        end else if (stop) begin
            st_nxt = PAL_I2C_IDLE;
            ack_nxt = 1'b0;
            drive_nxt = 1'b0;
        end else if (st_r != PAL_I2C_IDLE && scl_rise) begin
            if (ack_r) begin
                // Master not acknowledging ends the read
                if (st_r == PAL_I2C_RD && sda_in) begin
                    st_nxt = PAL_I2C_IDLE;
                end
            end else begin
                sh_nxt = (st_r == PAL_I2C_RD) ? {sh_r[6:0], 1'b0} : {sh_r[6:0], sda_in};
                cnt_nxt = cnt_r + 4'h1;
            end
        end else if (st_r != PAL_I2C_IDLE && scl_fall) begin
            if (ack_r) begin
                ack_nxt = 1'b0;
                drive_nxt = 1'b0;
                cnt_nxt = 4'h0;
                if (st_r == PAL_I2C_RD) begin
                    sh_nxt = rd_data;
                    drive_nxt = ~rd_data[7];
                    ptr_nxt = ptr_r + 8'h01;
                end
            end else if (cnt_r == 4'h8) begin
                ack_nxt = 1'b1;
                drive_nxt = 1'b1;
                case (st_r)
                    PAL_I2C_DEV: begin
                        if (sh_r[7:1] == DEV_ADDR) begin
                            st_nxt = sh_r[0] ? PAL_I2C_RD : PAL_I2C_SUB;
                        end else begin
                            st_nxt = PAL_I2C_IDLE;
                            ack_nxt = 1'b0;
                            drive_nxt = 1'b0;
                        end
                    end
                    PAL_I2C_SUB: begin
                        ptr_nxt = sh_r;
                        st_nxt = PAL_I2C_WR;
                    end
                    PAL_I2C_WR: begin
                        wr_nxt = 1'b1;
                        wr_addr_nxt = ptr_r;
                        wr_data_nxt = sh_r;
                        ptr_nxt = ptr_r + 8'h01;
                    end
                    default: begin
                        drive_nxt = 1'b0;
                    end
                endcase
            end else if (st_r == PAL_I2C_RD) begin
                drive_nxt = ~sh_r[7];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= PAL_I2C_IDLE;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            ack_r <= 1'b0;
            drive_r <= 1'b0;
            wr_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            scl_d_r <= scl_in;
            sda_d_r <= sda_in;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            ptr_r <= ptr_nxt;
            ack_r <= ack_nxt;
            drive_r <= drive_nxt;
            wr_r <= wr_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
        end
    end

endmodule

`default_nettype wire

// ==== design/pal_sync_mode.sv ====
// PAL sync, burst and mode control
`timescale 1ns/1ps
`default_nettype none
`include "pal_cfg.svh"

// Contract
// - In PAL the burst starts 5.6 us after the sync reference point and lasts 10 sub-carrier cycles.
// - The PAL vertical interval has 2.35 us equalizing pulses around 4.7 us serrated broad pulses, 64.0 us lines.
// - The PAL burst phase alternates between nominal +135 and -135 degrees on successive lines.
// - Burst phase comes from a free-running sub-carrier unrelated to the line rate, so it drifts slightly.
// - Six 8-bit registers sit at consecutive addresses; 0x00 to 0x04 are read-write and reset to 0x00.
// - Address 0x05 is a read-only identity register returning a fixed code.
// - The primary mode register resets to zero, giving NTSC with every option and the converter off.
// - Mode bits: 0 standard, 1 sub-carrier reset release, 2 video-ID line, 3 widescreen line, 7 converter.
// - Mode bit 4 clear times bars and black burst from the external syncs; set, timing is internal.
// - Internal timing stays in force during normal pixel input, unsynchronised to the incoming data.
// - Mode bit 5 turns on colour bars, but black burst wins when both are set.
// - Mode bit 6 turns black burst generation on or off.
// - Black burst encodes luma fixed at 16 and both chroma at 128.
// - Colour bars are 100 % amplitude, 75 % saturation.
module pal_sync_mode import pal_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = 7'h44,
    // Arbitrary identity value
    parameter logic [7:0] IDENT = 8'h5a,
    parameter int LINE_CYCLES = `PAL_LINE_CYC,
    parameter int LINES = `PAL_LINES,
    parameter logic [31:0] NCO_STEP = `PAL_NCO_STEP
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Serial host pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // External sync inputs
    input wire logic hsync_in_n,
    input wire logic vsync_in_n,
    // Pixel input and output
    input wire pal_pix_t pix_in,
    output pal_pix_t pix_out_r,
    // Timing outputs
    output logic sync_out_n_r,
    output logic burst_gate_r,
    output logic [7:0] burst_phase_r,
    // Mode and payload registers to the encoder
    output pal_mode_t mode_r,
    output logic [7:0] mode_sec_r,
    output logic [7:0] vbi_lo_r,
    output logic [7:0] vbi_hi_r,
    output logic [7:0] sync_adj_r
);

    localparam int HALF = LINE_CYCLES / 2;
    localparam int HS = `PAL_HSYNC_CYC;
    localparam int EQ = `PAL_EQ_CYC;
    localparam int BST = `PAL_BURST_CYC;
    localparam int ACT = `PAL_ACTIVE_CYC;
    localparam int BAR_W = `PAL_ACTLEN_CYC / 8;
    localparam int HW = $clog2(LINE_CYCLES);
    localparam int LW = $clog2(LINES + 1);

    if (LINE_CYCLES < 2 * (BST + HS) || LINES < 320 || BAR_W < 1) begin : g_chk
        $error("pal_sync_mode: line timing parameters too small");
    end

    // Register file and host access
    logic wr;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
    pal_mode_t mode_nxt;
    logic [7:0] mode_sec_nxt, vbi_lo_nxt, vbi_hi_nxt, sync_adj_nxt;

    pal_i2c_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_host (
        .clk(clk),
        .reset(reset),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .wr_r(wr),
        .wr_addr_r(wr_addr),
        .wr_data_r(wr_data),
        .ptr_r(rd_addr),
        .rd_data(rd_data)
    );

    always_comb begin
        mode_nxt = mode_r;
        mode_sec_nxt = mode_sec_r;
        vbi_lo_nxt = vbi_lo_r;
        vbi_hi_nxt = vbi_hi_r;
        sync_adj_nxt = sync_adj_r;
        if (wr) begin
            if (wr_addr == `PAL_OFS_MODE_PRI) begin
                mode_nxt = pal_mode_t'(wr_data);
            end else if (wr_addr == `PAL_OFS_MODE_SEC) begin
                mode_sec_nxt = wr_data;
            end else if (wr_addr == `PAL_OFS_VBI_LO) begin
                vbi_lo_nxt = wr_data;
            end else if (wr_addr == `PAL_OFS_VBI_HI) begin
                vbi_hi_nxt = wr_data;
            end else if (wr_addr == `PAL_OFS_SYNC_ADJ) begin
                sync_adj_nxt = wr_data;
            end
            // Identity and unmapped addresses take no write
        end
    end

    always_comb begin
        if (rd_addr == `PAL_OFS_MODE_PRI) begin
            rd_data = mode_r;
        end else if (rd_addr == `PAL_OFS_MODE_SEC) begin
            rd_data = mode_sec_r;
        end else if (rd_addr == `PAL_OFS_VBI_LO) begin
            rd_data = vbi_lo_r;
        end else if (rd_addr == `PAL_OFS_VBI_HI) begin
            rd_data = vbi_hi_r;
        end else if (rd_addr == `PAL_OFS_SYNC_ADJ) begin
            rd_data = sync_adj_r;
        end else if (rd_addr == `PAL_OFS_IDENT) begin
            rd_data = IDENT;
        end else begin
            rd_data = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_r <= pal_mode_t'(`PAL_RW_RESET);
            mode_sec_r <= `PAL_RW_RESET;
            vbi_lo_r <= `PAL_RW_RESET;
            vbi_hi_r <= `PAL_RW_RESET;
            sync_adj_r <= `PAL_RW_RESET;
        end else begin
            mode_r <= mode_nxt;
            mode_sec_r <= mode_sec_nxt;
            vbi_lo_r <= vbi_lo_nxt;
            vbi_hi_r <= vbi_hi_nxt;
            sync_adj_r <= sync_adj_nxt;
        end
    end

    // Half-line kind within the vertical interval of both fields
    function automatic pal_half_t half_kind(input logic [LW-1:0] line, input logic second);
        pal_half_t k;
        k = PAL_HALF_NORMAL;
        if (line == 10'd623) begin
            k = second ? PAL_HALF_EQ : PAL_HALF_NORMAL;
        end else if (line inside {10'd624, 10'd625, 10'd4, 10'd5}) begin
            k = PAL_HALF_EQ;
        end else if (line inside {10'd1, 10'd2}) begin
            k = PAL_HALF_BROAD;
        end else if (line == 10'd3) begin
            k = second ? PAL_HALF_EQ : PAL_HALF_BROAD;
        end else if (line inside {10'd311, 10'd312, 10'd316, 10'd317}) begin
            k = PAL_HALF_EQ;
        end else if (line == 10'd313) begin
            k = second ? PAL_HALF_BROAD : PAL_HALF_EQ;
        end else if (line inside {10'd314, 10'd315}) begin
            k = PAL_HALF_BROAD;
        end else if (line == 10'd318) begin
            k = second ? PAL_HALF_NORMAL : PAL_HALF_EQ;
        end
        return k;
    endfunction

    function automatic pal_pix_t bar_pix(input logic [2:0] idx);
        pal_pix_t p;
        case (idx)
            3'd0: p = 24'heb8080;
            3'd1: p = 24'ha22c8e;
            3'd2: p = 24'h839c2c;
            3'd3: p = 24'h70483a;
            3'd4: p = 24'h54b8c6;
            3'd5: p = 24'h4164d4;
            3'd6: p = 24'h23d472;
            default: p = 24'h108080;
        endcase
        return p;
    endfunction

    // Line timing, sub-carrier and burst
    logic [HW-1:0] h_r, h_nxt;
    logic [LW-1:0] line_r, line_nxt;
    logic hs_d_r, vs_d_r, vs_pend_r, vs_pend_nxt;
    logic [31:0] nco_r, nco_nxt;
    logic alt_r, alt_nxt, burst_nxt, sync_nxt;
    logic [3:0] bcnt_r, bcnt_nxt;
    logic [7:0] phase_nxt;
    logic line_end, second, sc_edge;
    logic [HW-1:0] th;
    pal_half_t kind;

    assign line_end = (h_r == HW'(LINE_CYCLES - 1));
    assign second = (h_r >= HW'(HALF));
    assign th = second ? h_r - HW'(HALF) : h_r;
    assign kind = half_kind(line_r, second);
    assign sc_edge = nco_nxt[31] & ~nco_r[31];

    always_comb begin
        h_nxt = line_end ? '0 : h_r + HW'(1);
        line_nxt = line_r;
        alt_nxt = alt_r;
        vs_pend_nxt = vs_pend_r | (vs_d_r & ~vsync_in_n);
        if (mode_r.self_timing_select) begin
            // Free running, not locked to incoming pixels
            vs_pend_nxt = 1'b0;
            if (line_end) begin
                line_nxt = (line_r == LW'(LINES)) ? LW'(1) : line_r + LW'(1);
                alt_nxt = ~alt_r;
            end
        end else if (hs_d_r & ~hsync_in_n) begin
            // External horizontal sync restarts the line
            h_nxt = '0;
            line_nxt = (vs_pend_nxt || line_r == LW'(LINES)) ? LW'(1) : line_r + LW'(1);
            vs_pend_nxt = 1'b0;
            alt_nxt = ~alt_r;
        end else if (line_end) begin
            h_nxt = h_r;
        end
        // Accumulator never re-phased to the line, so burst phase drifts
        nco_nxt = mode_r.subcarrier_reset_release ? nco_r + NCO_STEP : '0;
        // Sync pulse shape per half line
        case (kind)
            PAL_HALF_EQ: sync_nxt = ~(th < HW'(EQ));
            PAL_HALF_BROAD: sync_nxt = ~(th < HW'(HALF - HS));
            default: sync_nxt = ~(!second && h_r < HW'(HS));
        endcase
        burst_nxt = burst_gate_r;
        bcnt_nxt = bcnt_r;
        if (h_r == HW'(BST) && mode_r.video_standard_select &&
            half_kind(line_r, 1'b1) == PAL_HALF_NORMAL && kind == PAL_HALF_NORMAL) begin
            burst_nxt = 1'b1;
            bcnt_nxt = 4'h0;
        end else if (burst_gate_r && sc_edge) begin
            if (bcnt_r == 4'(`PAL_BURST_CYCLES - 1)) begin
                burst_nxt = 1'b0;
            end
            bcnt_nxt = bcnt_r + 4'h1;
        end
        phase_nxt = nco_nxt[31:24] + (alt_r ? `PAL_PH_MINUS : `PAL_PH_PLUS);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            h_r <= '0;
            line_r <= LW'(1);
            hs_d_r <= 1'b1;
            vs_d_r <= 1'b1;
            vs_pend_r <= 1'b0;
            nco_r <= '0;
            alt_r <= 1'b0;
            bcnt_r <= 4'h0;
            burst_gate_r <= 1'b0;
            burst_phase_r <= 8'h00;
            sync_out_n_r <= 1'b1;
        end else begin
            h_r <= h_nxt;
            line_r <= line_nxt;
            hs_d_r <= hsync_in_n;
            vs_d_r <= vsync_in_n;
            vs_pend_r <= vs_pend_nxt;
            nco_r <= nco_nxt;
            alt_r <= alt_nxt;
            bcnt_r <= bcnt_nxt;
            burst_gate_r <= burst_nxt;
            burst_phase_r <= phase_nxt;
            sync_out_n_r <= sync_nxt;
        end
    end

    // Test pattern source
    logic [2:0] bar_r, bar_nxt;
    logic [HW-1:0] bpos_r, bpos_nxt;
    pal_pix_t pix_nxt;

    always_comb begin
        bar_nxt = bar_r;
        bpos_nxt = bpos_r + HW'(1);
        if (h_r == HW'(ACT)) begin
            bar_nxt = 3'd0;
            bpos_nxt = '0;
        end else if (bpos_r == HW'(BAR_W - 1)) begin
            bpos_nxt = '0;
            bar_nxt = (bar_r == 3'd7) ? bar_r : bar_r + 3'd1;
        end
        if (mode_r.black_level_enable) begin
            // Black wins over bars
            pix_nxt = {`PAL_BLACK_Y, `PAL_BLACK_C, `PAL_BLACK_C};
        end else if (mode_r.colour_bar_enable) begin
            pix_nxt = bar_pix(bar_r);
        end else begin
            pix_nxt = pix_in;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bar_r <= 3'd7;
            bpos_r <= '0;
            pix_out_r <= {`PAL_BLACK_Y, `PAL_BLACK_C, `PAL_BLACK_C};
        end else begin
            bar_r <= bar_nxt;
            bpos_r <= bpos_nxt;
            pix_out_r <= pix_nxt;
        end
    end

endmodule

`default_nettype wire

// ==== test/pal_sync_mode_props.sv ====
// Port assertions for the PAL sync block
`timescale 1ns/1ps
`default_nettype none
module pal_sync_mode_props import pal_pkg::*; #(
    parameter int LINE_CYCLES = 12800
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Watched ports
    input wire pal_pix_t pix_in,
    input wire pal_pix_t pix_out_r,
    input wire logic sync_out_n_r,
    input wire logic burst_gate_r,
    input wire logic [7:0] burst_phase_r,
    input wire pal_mode_t mode_r,
    input wire logic [7:0] mode_sec_r,
    input wire logic [7:0] vbi_lo_r,
    input wire logic [7:0] vbi_hi_r,
    input wire logic [7:0] sync_adj_r
);
    localparam int HALF = LINE_CYCLES / 2;
    logic sync_q_r, sync_q_nxt, seen_r, seen_nxt;
    logic [15:0] since_r, since_nxt, low_r, low_nxt, gate_r, gate_nxt;
    logic fell;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Period checked only after a first edge in self timing
    always_comb begin
        fell = sync_q_r && !sync_out_n_r;
        since_nxt = fell ? 16'h1 : since_r + 16'h1;
        low_nxt = sync_out_n_r ? 16'h0 : low_r + 16'h1;
        gate_nxt = burst_gate_r ? gate_r + 16'h1 : 16'h0;
        seen_nxt = mode_r.self_timing_select && (seen_r || fell);
        sync_q_nxt = sync_out_n_r;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            since_r <= 16'h0;
            low_r <= 16'h0;
            gate_r <= 16'h0;
            seen_r <= 1'b0;
            sync_q_r <= 1'b1;
        end else begin
            since_r <= since_nxt;
            low_r <= low_nxt;
            gate_r <= gate_nxt;
            seen_r <= seen_nxt;
            sync_q_r <= sync_q_nxt;
        end
    end

    a_regs_reset: assert property (disable iff (1'b0)
        reset |=> {mode_r, mode_sec_r, vbi_lo_r, vbi_hi_r, sync_adj_r} == 40'h0)
        else $error("regs not reset");
    a_black_pix: assert property (mode_r.black_level_enable |=> pix_out_r == 24'h108080)
        else $error("black pixel");
    a_pass_thru: assert property (!mode_r.black_level_enable && !mode_r.colour_bar_enable
        |=> pix_out_r == $past(pix_in))
        else $error("no pass-through");
    a_sync_width: assert property ($rose(sync_out_n_r)
        |-> low_r == 16'h1d6 || low_r == 16'h3ac || low_r == 16'(HALF - 940))
        else $error("sync width");
    a_line_period: assert property ($fell(sync_out_n_r) && seen_r
        |-> since_r == 16'(HALF) || since_r == 16'(LINE_CYCLES))
        else $error("sync spacing");
    a_burst_start: assert property ($rose(burst_gate_r) |-> since_r == 16'h460)
        else $error("burst start");
    a_burst_len: assert property ($fell(burst_gate_r) |-> gate_r >= 16'h195 && gate_r <= 16'h1c5)
        else $error("burst length");
    a_burst_pal: assert property ($rose(burst_gate_r) |-> $past(mode_r.video_standard_select))
        else $error("burst outside PAL");
    a_phase_step: assert property (burst_gate_r && $past(burst_gate_r)
        |-> 8'(burst_phase_r - $past(burst_phase_r)) inside {8'h05, 8'h06})
        else $error("phase step");

    c_burst: cover property ($rose(burst_gate_r));
    c_bars: cover property (mode_r.colour_bar_enable && !mode_r.black_level_enable);
    c_black: cover property (mode_r.black_level_enable);
endmodule

bind pal_sync_mode pal_sync_mode_props #(.LINE_CYCLES(LINE_CYCLES)) u_props (
    .clk(clk), .reset(reset), .pix_in(pix_in), .pix_out_r(pix_out_r), .sync_out_n_r(sync_out_n_r),
    .burst_gate_r(burst_gate_r), .burst_phase_r(burst_phase_r), .mode_r(mode_r), .mode_sec_r(mode_sec_r),
    .vbi_lo_r(vbi_lo_r), .vbi_hi_r(vbi_hi_r), .sync_adj_r(sync_adj_r)
);
`default_nettype wire

// ==== test/pal_host_model.sv ====
// Two-wire host model for register access
`timescale 1ns/1ps
`default_nettype none
module pal_host_model (
    // Bus
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    // Quarter bit in clocks
    localparam int Q = 10;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick();
        repeat (Q) @(posedge clk);
        #1;
    endtask
    task automatic start();
        sda_pull = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda_pull = 1'b1;
        tick();
        scl = 1'b0;
        tick();
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda_pull = 1'b0;
        tick();
    endtask
    // Eight bits and the acknowledge slot; 1 releases
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic nak);
        logic [8:0] w;
        w = {d, last};
        for (int i = 8; i >= 0; i--) begin
            sda_pull = !w[i];
            tick();
            scl = 1'b1;
            tick();
            w[i] = sda;
            tick();
            scl = 1'b0;
            tick();
        end
        q = w[8:1];
        nak = w[0];
    endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the PAL sync block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int LC = 4400;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
    localparam logic [6:0] DEV = 7'h44;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hs_n = 1'b1;
    logic vs_n = 1'b1;
    pal_pkg::pal_pix_t pix_in = 24'h0;
    pal_pkg::pal_pix_t pix_out;
    pal_pkg::pal_mode_t mode;
    logic scl, pull, sda_oe, sync_n, gate;
    logic [7:0] phase, sec, vlo, vhi, adj;
    wire sda = !(pull || sda_oe);
    int num_errors = 0;
    int checked = 0;

    always #2.5 clk = !clk;

    pal_sync_mode #(.DEV_ADDR(DEV), .IDENT(ID), .LINE_CYCLES(LC)) u_dut (
        .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .hsync_in_n(hs_n), .vsync_in_n(vs_n), .pix_in(pix_in), .pix_out_r(pix_out),
        .sync_out_n_r(sync_n), .burst_gate_r(gate), .burst_phase_r(phase), .mode_r(mode),
        .mode_sec_r(sec), .vbi_lo_r(vlo), .vbi_hi_r(vhi), .sync_adj_r(adj)
    );
    pal_host_model u_host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkpix(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] sub, input logic [31:0] v, input int n);
        logic [7:0] q;
        logic nak;
        u_host.start();
        u_host.xfer({DEV, 1'b0}, 1'b1, q, nak);
        u_host.xfer(sub, 1'b1, q, nak);
        for (int i = 0; i < n; i++) begin
            u_host.xfer(v[31-8*i -: 8], 1'b1, q, nak);
        end
        u_host.stop();
        chk8(8'(nak), 8'h00);
    endtask
    task automatic rd(input logic [7:0] sub, output logic [7:0] q);
        logic nak;
        u_host.start();
        u_host.xfer({DEV, 1'b0}, 1'b1, q, nak);
        u_host.xfer(sub, 1'b1, q, nak);
        u_host.start();
        u_host.xfer({DEV, 1'b1}, 1'b1, q, nak);
        u_host.xfer(8'hff, 1'b1, q, nak);
        u_host.stop();
    endtask

    task automatic t_regs();
        logic [7:0] q;
        for (int a = 0; a < 6; a++) begin
            rd(8'(a), q);
            chk8(q, (a == 5) ? ID : 8'h00);
        end
        wr(8'h01, 32'h1b2c3d4e, 4);
        wr(8'h05, 32'hff000000, 1);
        chk8(sec, 8'h1b);
        chk8(vlo, 8'h2c);
        chk8(adj, 8'h4e);
        rd(8'h03, q);
        chk8(q, 8'h3d);
        rd(8'h05, q);
        chk8(q, ID);
        wr(8'h00, 32'h8f000000, 1);
        chk8(8'(mode.widescreen_line_enable), 8'h01);
        chk8(mode, 8'h8f);
    endtask
    task automatic t_ext();
        int falls;
        logic prev;
        wr(8'h00, 32'h0, 1);
        hs_n = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk8(8'(sync_n), 8'h00);
        hs_n = 1'b1;
        falls = 0;
        prev = sync_n;
        repeat (LC + 200) begin
            @(posedge clk);
            #1;
            falls += int'(prev && !sync_n);
            prev = sync_n;
        end
        // Broad line 2 falls once mid-line
        chk8(8'(falls), 8'h01);
    endtask
    task automatic t_pix();
        pix_in = 24'h5a3c96;
        wr(8'h00, 32'h60000000, 1);
        chkpix(pix_out, 24'h108080);
        wr(8'h00, 32'h0, 1);
        chkpix(pix_out, 24'h5a3c96);
    endtask
    task automatic t_bars();
        int n;
        wr(8'h00, 32'h33000000, 1);
        n = 0;
        while (n != 940) begin
            @(negedge sync_n);
            n = 0;
            while (!sync_n) begin
                @(posedge clk);
                #1;
                n++;
            end
        end
        repeat (1810) @(posedge clk);
        chkpix(pix_out, 24'heb8080);
        repeat (1300) @(posedge clk);
        chkpix(pix_out, 24'ha22c8e);
    endtask
    task automatic t_phase();
        logic [7:0] ph [3];
        longint tr [3];
        logic [63:0] p;
        logic [7:0] e0, e1;
        wr(8'h00, 32'h13000000, 1);
        for (int i = 0; i < 3; i++) begin
            @(posedge gate);
            #1;
            ph[i] = phase;
            tr[i] = $time;
            // Line sync input must not disturb self timing
            hs_n = 1'b0;
            @(posedge clk);
            #1;
            hs_n = 1'b1;
        end
        p = 64'(LC) * 64'h05accef2;
        e0 = ph[1] - ph[0] - p[31:24];
        e1 = ph[2] - ph[1] - p[31:24];
        chk8(e0 & 8'h7e, 8'h40);
        chk8(e1 & 8'h7e, 8'h40);
        chk8(8'(e0[7] ^ e1[7]), 8'h01);
        chk8(8'((tr[1] - tr[0]) / 5 - LC), 8'h00);
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        #1;
        reset = 1'b0;
        t_regs();
        t_ext();
        t_pix();
        t_bars();
        t_phase();
        summarize();
    end
    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
